// [hw/acr_pkg.sv]
// Constants shared by the converter control register block.
// Assumes a 32-bit APB bus and byte addresses of four times the register index.
package acr_pkg;

  // Bus shape
  localparam int unsigned ACR_ADDR_W = 16;
  localparam int unsigned ACR_DATA_W = 32;

  // Register indices as printed, byte addresses are four times these
  localparam logic [11:0] IDX_CONVERTER_CONTROL = 12'hF70;
  localparam logic [11:0] IDX_RESULT_HIGH_BYTE  = 12'hF72;
  localparam logic [11:0] IDX_RESULT_LOW_BITS   = 12'hF73;
  localparam logic [15:0] ADDR_CONVERTER_CONTROL = {2'h0, IDX_CONVERTER_CONTROL, 2'h0};
  localparam logic [15:0] ADDR_RESULT_HIGH_BYTE  = {2'h0, IDX_RESULT_HIGH_BYTE, 2'h0};
  localparam logic [15:0] ADDR_RESULT_LOW_BITS   = {2'h0, IDX_RESULT_LOW_BITS, 2'h0};

  // Control register fields
  localparam int unsigned CTRL_GO_BIT     = 7;
  localparam int unsigned CTRL_RSVD_BIT   = 6;
  localparam int unsigned CTRL_REF_BIT    = 5;
  localparam int unsigned CTRL_REPEAT_BIT = 4;
  localparam int unsigned CTRL_CHAN_MSB   = 3;
  localparam int unsigned CHAN_W          = 4;
  localparam logic [3:0]  CHAN_RESET      = 4'h0;
  localparam logic        REF_EXT_RESET   = 1'b0;
  localparam logic        REPEAT_RESET    = 1'b0;

  // Result layout
  localparam int unsigned RESULT_W     = 10;
  localparam int unsigned LOW_FIELD_LSB = 6;
  localparam logic [7:0]  HIGH_RESET    = 8'h00;
  localparam logic [1:0]  LOW_RESET     = 2'h0;

  // Timing in system clock cycles
  localparam int unsigned SINGLE_CYCLES_DEF = 5129;
  localparam int unsigned REPEAT_CONVERSION_CYCLES_DEF   = 256;
  localparam int unsigned WAKE_CYCLES_DEF   = 40;
  localparam int unsigned IDLE_CYCLES_DEF   = 160;
  localparam int unsigned CNT_W             = 13;
  localparam int unsigned IDLE_W            = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAKE = 2'b01,
    ST_CONV = 2'b10
  } acr_state_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_HIGH = 2'b10,
    SEL_LOW  = 2'b11
  } acr_sel_t;

endpackage : acr_pkg

// [hw/acr_control_regs.sv]
// Converter control and result registers behind an APB slave, with conversion timing.
// Assumes the converter core delivers resultIn on clk_sys, valid in the cycle a conversion ends.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module acr_control_regs
  import acr_pkg::*;
#(
  parameter int unsigned SINGLE_CYCLES = acr_pkg::SINGLE_CYCLES_DEF,
  parameter int unsigned REPEAT_CONVERSION_CYCLES   = acr_pkg::REPEAT_CONVERSION_CYCLES_DEF,
  parameter int unsigned WAKE_CYCLES   = acr_pkg::WAKE_CYCLES_DEF,
  parameter int unsigned IDLE_CYCLES   = acr_pkg::IDLE_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
  input  wire logic [acr_pkg::ACR_DATA_W-1:0] pwdata,
  output logic      [acr_pkg::ACR_DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Converter core
  input  wire logic [acr_pkg::RESULT_W-1:0]  resultIn,
  output logic      [acr_pkg::CHAN_W-1:0]    channelSelect,
  output logic                               refInternalOn,
  output logic                               converterPowered,
  output logic                               convBusy,
  // Interrupt controller
  output logic                               conversionIrq
);
  import acr_pkg::*;

  if (SINGLE_CYCLES < 2 || SINGLE_CYCLES >= (1 << CNT_W) || REPEAT_CONVERSION_CYCLES < 2 || REPEAT_CONVERSION_CYCLES >= (1 << CNT_W) ||
      WAKE_CYCLES < 2 || WAKE_CYCLES >= (1 << CNT_W) || IDLE_CYCLES < 2 || IDLE_CYCLES >= (1 << IDLE_W)) begin : g_chk
    $error("acr_control_regs: cycle count parameter out of range");
  end

  localparam logic [CNT_W-1:0]  SINGLE_LAST = CNT_W'(SINGLE_CYCLES - 1);
  localparam logic [CNT_W-1:0]  REPEAT_CONVERSION_LAST   = CNT_W'(REPEAT_CONVERSION_CYCLES - 1);
  localparam logic [CNT_W-1:0]  WAKE_LAST   = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST   = IDLE_W'(IDLE_CYCLES - 1);
  localparam int unsigned       SPAN_W      = CNT_W + 1;
  localparam logic [SPAN_W-1:0] SPAN_SINGLE = SPAN_W'(SINGLE_CYCLES - 1);
  localparam logic [SPAN_W-1:0] SPAN_WOKEN  = SPAN_W'(SINGLE_CYCLES + WAKE_CYCLES - 1);
  localparam logic [SPAN_W-1:0] SPAN_REPEAT_CONVERSION   = SPAN_W'(REPEAT_CONVERSION_CYCLES - 1);

  function automatic acr_sel_t decodeSel(input logic [ACR_ADDR_W-1:0] addr);
    if (addr == ADDR_CONVERTER_CONTROL) begin
      return SEL_CTRL;
    end else if (addr == ADDR_RESULT_HIGH_BYTE) begin
      return SEL_HIGH;
    end else if (addr == ADDR_RESULT_LOW_BITS) begin
      return SEL_LOW;
    end else begin
      return SEL_NONE;
    end
  endfunction : decodeSel

  acr_state_t         state;
  acr_sel_t           sel;
  logic [CNT_W-1:0]   cycleCnt;
  logic [IDLE_W-1:0]  idleCnt;
  logic               firstConv;
  logic               goBit;
  logic               refExternal;
  logic               repeatMode;
  logic [7:0]         resultHigh;
  logic [1:0]         newestLow;
  logic [1:0]         lowLatch;
  logic [1:0]         lowPend;
  logic               setupPhase;
  logic               accessDone;
  logic               ctrlWrite;
  logic               startReq;
  logic               convDone;
  logic               highReadDone;

  assign sel          = decodeSel(paddr);
  assign setupPhase   = psel && !penable;
  assign accessDone   = psel && penable && pready;
  assign ctrlWrite    = accessDone && pwrite && (sel == SEL_CTRL);
  assign startReq     = ctrlWrite && pwdata[CTRL_GO_BIT];
  assign highReadDone = accessDone && !pwrite && (sel == SEL_HIGH);
  assign convDone     = (state == ST_CONV) && (cycleCnt == (firstConv ? SINGLE_LAST : REPEAT_CONVERSION_LAST));

  // Conversion sequencer; a start request overrides every other step
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      cycleCnt  <= '0;
      firstConv <= 1'b0;
    end else if (startReq) begin
      state     <= converterPowered ? ST_CONV : ST_WAKE;
      cycleCnt  <= '0;
      firstConv <= 1'b1;
    end else begin
      case (state)
        ST_WAKE: begin
          if (cycleCnt == WAKE_LAST) begin
            state    <= ST_CONV;
            cycleCnt <= '0;
          end else begin
            cycleCnt <= cycleCnt + 1'b1;
          end
        end
        ST_CONV: begin
          if (convDone) begin
            cycleCnt  <= '0;
            firstConv <= 1'b0;
            if (!repeatMode) begin
              state <= ST_IDLE;
            end
          end else begin
            cycleCnt <= cycleCnt + 1'b1;
          end
        end
        default: begin
          cycleCnt <= '0;
        end
      endcase
    end
  end

  // Automatic power-down after a run of idle cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idleCnt          <= '0;
      converterPowered <= 1'b0;
    end else if (state == ST_WAKE && cycleCnt == WAKE_LAST && !startReq) begin
      idleCnt          <= '0;
      converterPowered <= 1'b1;
    end else if (state != ST_IDLE || startReq) begin
      idleCnt <= '0;
    end else if (idleCnt == IDLE_LAST) begin
      converterPowered <= 1'b0;
    end else begin
      idleCnt <= idleCnt + 1'b1;
    end
  end

  // Go bit: a start write wins over the end of a conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      goBit <= 1'b0;
    end else if (startReq) begin
      goBit <= 1'b1;
    end else if (convDone && firstConv) begin
      goBit <= 1'b0;
    end
  end

  // Control fields
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refExternal   <= REF_EXT_RESET;
      refInternalOn <= !REF_EXT_RESET;
      repeatMode    <= REPEAT_RESET;
      channelSelect <= CHAN_RESET;
    end else if (ctrlWrite) begin
      refExternal   <= pwdata[CTRL_REF_BIT];
      refInternalOn <= !pwdata[CTRL_REF_BIT];
      repeatMode    <= pwdata[CTRL_REPEAT_BIT];
      channelSelect <= pwdata[CTRL_CHAN_MSB -: CHAN_W];
    end
  end

  // Results are loaded only by the sequencer, never by the bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resultHigh <= HIGH_RESET;
      newestLow  <= LOW_RESET;
    end else if (convDone) begin
      resultHigh <= resultIn[RESULT_W-1 -: 8];
      newestLow  <= resultIn[1:0];
    end
  end

  // Low bits pair with the high byte seen at the setup edge of its read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lowPend  <= LOW_RESET;
      lowLatch <= LOW_RESET;
    end else begin
      if (setupPhase && !pwrite && sel == SEL_HIGH) begin
        lowPend <= newestLow;
      end
      if (highReadDone) begin
        lowLatch <= lowPend;
      end
    end
  end

  // APB answer: one access cycle, no wait states
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && (sel == SEL_NONE);
      if (setupPhase && !pwrite) begin
        if (sel == SEL_CTRL) begin
          prdata <= {24'h000000, goBit, 1'b0, refExternal, repeatMode, channelSelect};
        end else if (sel == SEL_HIGH) begin
          prdata <= {24'h000000, resultHigh};
        end else if (sel == SEL_LOW) begin
          prdata <= {24'h000000, lowLatch, 6'h00};
        end else begin
          prdata <= '0;
        end
      end
    end
  end

  // Core-facing status and interrupt request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conversionIrq <= 1'b0;
      convBusy      <= 1'b0;
    end else begin
      conversionIrq <= convDone;
      convBusy      <= startReq || (state != ST_IDLE && !(convDone && !repeatMode));
    end
  end

  // Check-only span since the last start or conversion end, kept apart from the sequencer count
  logic [SPAN_W-1:0]  chkSpan;
  logic               chkWoke;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chkSpan <= '0;
      chkWoke <= 1'b0;
    end else if (startReq) begin
      chkSpan <= '0;
      chkWoke <= !converterPowered;
    end else if (convDone) begin
      chkSpan <= '0;
      chkWoke <= 1'b0;
    end else begin
      chkSpan <= chkSpan + 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_done_pulse;
    convDone ##1 (conversionIrq && !convDone) ##1 !conversionIrq;
  endsequence

  sequence s_irq_pulse;
    conversionIrq ##1 !conversionIrq;
  endsequence

  property p_irq_per_done;
    convDone && !startReq && !repeatMode |-> ##1 s_irq_pulse;
  endproperty

  a_go_on_start: assert property (startReq |=> goBit && state != ST_IDLE && cycleCnt == '0)
    else $error("go bit or sequencer not started by go write");

  a_restart_clears: assert property ((state == ST_CONV && startReq) |=> firstConv && cycleCnt == '0)
    else $error("running conversion not restarted");

  a_go_falls_done: assert property ($fell(goBit) |-> $past(convDone) && $past(firstConv))
    else $error("go bit cleared without a finished conversion");

  a_zero_write_keeps: assert property ((ctrlWrite && !pwdata[CTRL_GO_BIT] && goBit && !convDone) |=> goBit)
    else $error("writing go as zero changed it");

  a_ref_follows_bit: assert property (ctrlWrite |=> refInternalOn == !$past(pwdata[CTRL_REF_BIT]))
    else $error("internal reference enable not following control bit");

  a_single_length: assert property ((convDone && firstConv)
                                    |-> chkSpan == (chkWoke ? SPAN_WOKEN : SPAN_SINGLE))
    else $error("first conversion length wrong");

  a_repeat_conversion_period: assert property ((convDone && !firstConv) |-> chkSpan == SPAN_REPEAT_CONVERSION)
    else $error("continuous conversion period wrong");

  a_result_loaded: assert property (convDone |=> resultHigh == $past(resultIn[RESULT_W-1 -: 8]) &&
                                                 newestLow == $past(resultIn[1:0]))
    else $error("result not loaded at conversion end");

  a_low_pair_read: assert property ((setupPhase && !pwrite && sel == SEL_HIGH) ##1 highReadDone
                                    |=> lowLatch == $past(newestLow, 2))
    else $error("low bits not paired with high byte read");

  a_low_stable: assert property (!highReadDone |=> $stable(lowLatch))
    else $error("low bits changed without a high byte read");

  a_ro_results: assert property ((accessDone && pwrite && sel != SEL_CTRL && !convDone) |=> $stable(resultHigh))
    else $error("write changed a result register");

  a_repeat_conversion_go_low: assert property ((state == ST_CONV && !firstConv && !startReq) |-> !goBit)
    else $error("go bit set during later continuous conversions");

  a_irq_pulse: assert property (p_irq_per_done)
    else $error("interrupt request not a single pulse after conversion");

  a_irq_cause: assert property (conversionIrq |-> $past(convDone))
    else $error("interrupt request without a finished conversion");

  a_done_pulse_seq: assert property ((convDone && !repeatMode && !startReq) |-> s_done_pulse)
    else $error("completion pulse sequence broken");

  a_wake_length: assert property ((state == ST_WAKE && !startReq) ##1 (state == ST_CONV)
                                  |-> $past(cycleCnt) == CNT_W'(WAKE_CYCLES - 1))
    else $error("power-up delay length wrong");

  a_wake_when_down: assert property ((startReq && !converterPowered) |=> state == ST_WAKE)
    else $error("start from power-down skipped the wake-up delay");

  a_busy_while_go: assert property (goBit |-> convBusy)
    else $error("go bit set while the converter is not busy");

  a_conv_powered: assert property ((state == ST_CONV) |-> converterPowered)
    else $error("converting while powered down");

  a_chan_follows: assert property (ctrlWrite |=> channelSelect == $past(pwdata[CTRL_CHAN_MSB -: CHAN_W]))
    else $error("channel select not following control field");

endmodule : acr_control_regs

// [test/acr_core_model.sv]
// Behavioural converter core for the control register bench.
// Assumes one result per conversionIrq pulse, all on clk_sys.
`timescale 1ns/1ps

module acr_core_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control side
  input  wire logic [3:0] channelSelect,
  input  wire logic       conversionIrq,
  // Result side
  output logic      [9:0] resultIn
);
  logic [5:0] epoch;

  // Result tags the channel and the count of finished conversions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      epoch <= 6'h00;
    end else if (conversionIrq) begin
      epoch <= epoch + 6'h01;
    end
  end

  assign resultIn = {channelSelect, epoch};
endmodule : acr_core_model

// [test/adc_control_registers_tb.sv]
// Self-checking bench for the converter control register block.
// Assumes the small timing parameters below and an APB slave with no wait states.
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module adc_control_registers_tb;
  import acr_pkg::*;
  localparam int S = 20;
  localparam int C = 8;
  localparam int W = 4;
  localparam int I = 6;

  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  resultIn;
  logic [3:0]  channelSelect;
  logic        refInternalOn;
  logic        converterPowered;
  logic        convBusy;
  logic        conversionIrq;
  int          n_fail;
  int          check_count;
  int          nIrq;
  logic [31:0] rd;
  logic        er;
  logic [9:0]  exp;
  int          n;

  acr_control_regs #(.SINGLE_CYCLES(S), .REPEAT_CONVERSION_CYCLES(C), .WAKE_CYCLES(W), .IDLE_CYCLES(I)) uut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .resultIn(resultIn),
    .channelSelect(channelSelect), .refInternalOn(refInternalOn), .converterPowered(converterPowered),
    .convBusy(convBusy), .conversionIrq(conversionIrq));

  acr_core_model core (.clk_sys(clk_sys), .rst(rst), .channelSelect(channelSelect),
    .conversionIrq(conversionIrq), .resultIn(resultIn));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (conversionIrq === 1'b1) nIrq <= nIrq + 1;
  end

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (conversionIrq !== 1'b1 && n < 20000);
  endtask : wait_irq

  task automatic t_reset();
    apb(1'b0, ADDR_CONVERTER_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(refInternalOn, 1'b1)
    `CHK(converterPowered, 1'b0)
    apb(1'b0, 16'h0000, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0000_0000)
    $display("test reset done");
  endtask : t_reset

  task automatic t_single();
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_00A3);
    wait_irq();
    exp = {4'h3, nIrq[5:0]};
    `CHK(n, W + S)
    `CHK(channelSelect, 4'h3)
    `CHK(refInternalOn, 1'b0)
    apb(1'b0, ADDR_CONVERTER_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_0023)
    apb(1'b1, ADDR_RESULT_HIGH_BYTE, 32'h0000_00FF);
    apb(1'b0, ADDR_RESULT_HIGH_BYTE, 32'h0);
    `CHK(rd, {24'h0, exp[9:2]})
    apb(1'b0, ADDR_RESULT_LOW_BITS, 32'h0);
    `CHK(rd[7:6], exp[1:0])
    $display("test single done");
  endtask : t_single

  task automatic t_restart();
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_0080);
    repeat (6) @(posedge clk_sys);
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_0000);
    apb(1'b0, ADDR_CONVERTER_CONTROL, 32'h0);
    `CHK(rd[7], 1'b1)
    `CHK(convBusy, 1'b1)
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_0087);
    wait_irq();
    `CHK(n, S)
    $display("test restart done");
  endtask : t_restart

  task automatic t_repeat_conversion();
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_0095);
    wait_irq();
    `CHK(n, S)
    wait_irq();
    exp = {4'h5, nIrq[5:0]};
    `CHK(n, C)
    apb(1'b0, ADDR_RESULT_HIGH_BYTE, 32'h0);
    `CHK(rd[7:0], exp[9:2])
    wait_irq();
    apb(1'b0, ADDR_RESULT_LOW_BITS, 32'h0);
    `CHK(rd[7:6], exp[1:0])
    apb(1'b0, ADDR_CONVERTER_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_0015)
    wait_irq();
    `CHK(n < C, 1'b1)
    apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h0000_0005);
    repeat (C + 3) @(posedge clk_sys);
    `CHK(convBusy, 1'b0)
    repeat (I + 3) @(posedge clk_sys);
    `CHK(converterPowered, 1'b0)
    $display("test continuous done");
  endtask : t_repeat_conversion

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    n_fail = 0;
    check_count = 0;
    nIrq = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_restart();
    t_repeat_conversion();
    summarize();
  end

  initial begin
    #(40 * 5000);
    n_fail++;
    summarize();
  end
endmodule : adc_control_registers_tb
